// file: pss_decoder.sv
// Patch shader stage state decoder: the device end of the state link.
// Assumes the streamer is on the same clock and follows the fence order.
// What this block does
// - Accept only the exact stage state header
// - Sampler count in fours, codes 5-7 reserved
// - Binding table count feeds prefetch only
// - Max threads minus one limits concurrent threads
// - Fence follows max thread change before draw
// - Tessellation stages enabled or disabled together
// - Kernel pointer bits 31:6, 64-byte aligned
// - Software reserves scratch for all threads
// - Scratch size exponent 0-11, 1KB to 2MB
// - Dispatch bit 27 selects single program flow
`timescale 1ns/1ps
module pss_decoder
    import pss_pkg::*;
(
    input  wire logic         CLK_SYS_IN,
    input  wire logic         RST_B_IN,
    pss_link_if.dev           link,
    input  wire logic         PATCH_VALID_IN,
    input  wire logic         THREAD_DONE_IN,
    output logic              PATCH_READY_OUT,
    output logic              DISPATCH_VALID_OUT,
    output logic [3:0]        DISPATCH_INSTANCE_OUT,
    output logic [31:0]       KERNEL_ADDR_OUT,
    output logic              SINGLE_FLOW_OUT,
    output logic [2:0]        SAMPLER_CODE_OUT,
    output logic [4:0]        SAMPLER_PREFETCH_OUT,
    output logic [7:0]        BINDING_PREFETCH_OUT,
    output logic              FP_ALT_MODE_OUT,
    output logic              ILLEGAL_EXC_EN_OUT,
    output logic              SOFTWARE_EXC_EN_OUT,
    output logic [6:0]        MAX_THREADS_OUT,
    output logic              STAGE_ENABLE_OUT,
    output logic              STATS_ENABLE_OUT,
    output logic [3:0]        INSTANCE_COUNT_OUT,
    output logic [31:0]       SCRATCH_BASE_OUT,
    output logic [3:0]        SCRATCH_EXP_OUT,
    output logic [7:0]        ACTIVE_THREADS_OUT,
    output logic [31:0]       INVOCATIONS_OUT,
    output logic              PACKET_DONE_OUT,
    output logic              HEADER_ERR_OUT,
    output logic              RANGE_ERR_OUT,
    output logic              FENCE_ERR_OUT,
    output logic              TESS_ERR_OUT
);
    typedef struct packed {
        pss_dev_st_t st;
        logic [2:0]  idx;
        logic        rdy;
        logic [31:0] d1;
        logic [31:0] d2;
        logic [31:0] d3;
        logic [31:0] d4;
        logic [31:0] d5;
        logic [2:0]  samp;
        logic [4:0]  samp_pf;
        logic [7:0]  bt;
        logic        fp;
        logic        ill_exc;
        logic        sw_exc;
        logic [6:0]  max_thr;
        logic        enable;
        logic        stats;
        logic [3:0]  inst;
        logic [25:0] kernel;
        logic [21:0] scr_base;
        logic [3:0]  scr_exp;
        logic        sflow;
        logic        fence_due;
        logic        pkt_done;
        logic        hdr_err;
        logic        range_err;
        logic        fence_err;
        logic        tess_err;
        logic [31:0] invoc;
    } pss_dec_s_t;

    pss_dec_s_t s_reg;
    pss_dec_s_t s_next;
    logic       take;
    logic [6:0] new_max;
    logic [6:0] new_lim;
    logic       patch_done;

    pss_dispatch u_dispatch (
        .clk_in          (CLK_SYS_IN),
        .rst_b_in        (RST_B_IN),
        .enable_in       (s_reg.enable),
        .max_thr_in      (s_reg.max_thr),
        .inst_cnt_in     (s_reg.inst),
        .patch_valid_in  (PATCH_VALID_IN),
        .thread_done_in  (THREAD_DONE_IN),
        .patch_ready_out (PATCH_READY_OUT),
        .disp_valid_out  (DISPATCH_VALID_OUT),
        .disp_inst_out   (DISPATCH_INSTANCE_OUT),
        .patch_done_out  (patch_done),
        .active_out      (ACTIVE_THREADS_OUT)
    );

    always_comb begin
        s_next          = s_reg;
        s_next.rdy      = 1'b1;
        s_next.pkt_done = 1'b0;
        take            = link.cmd_valid && s_reg.rdy;
        new_max         = s_reg.d1[6:0];
        new_lim         = (new_max > PSS_THR_MAX) ? PSS_THR_MAX : new_max;
        if (take && link.cmd_kind == PSS_KIND_STATE) begin
            case (s_reg.st)
                PSS_DEV_HDR: begin
                    if (link.cmd_data == pss_header()) begin
                        s_next.st  = PSS_DEV_BODY;
                        s_next.idx = 3'h1;
                    end else begin
                        s_next.hdr_err = 1'b1;
                        s_next.st      = PSS_DEV_SKIP;
                        s_next.idx     = 3'h1;
                    end
                end
                PSS_DEV_BODY: begin
                    s_next.idx = s_reg.idx + 3'h1;
                    case (s_reg.idx)
                        3'h1: s_next.d1 = link.cmd_data;
                        3'h2: s_next.d2 = link.cmd_data;
                        3'h3: s_next.d3 = link.cmd_data;
                        3'h4: s_next.d4 = link.cmd_data;
                        3'h5: s_next.d5 = link.cmd_data;
                        default: s_next.d5 = s_reg.d5;
                    endcase
                    if (s_reg.idx == PSS_LAST_IDX) begin
                        // Commit the whole packet at once so consumers never see a mix
                        s_next.st       = PSS_DEV_HDR;
                        s_next.pkt_done = 1'b1;
                        s_next.samp     = s_reg.d1[PSS_SAMP_LSB +: 3];
                        s_next.samp_pf  = pss_samp_prefetch(s_reg.d1[PSS_SAMP_LSB +: 3]);
                        s_next.bt       = s_reg.d1[PSS_BT_LSB +: 8];
                        s_next.fp       = s_reg.d1[PSS_FP_BIT];
                        s_next.ill_exc  = s_reg.d1[PSS_ILL_BIT];
                        s_next.sw_exc   = s_reg.d1[PSS_SWX_BIT];
                        s_next.max_thr  = new_lim;
                        s_next.enable   = s_reg.d2[PSS_EN_BIT];
                        s_next.stats    = s_reg.d2[PSS_STAT_BIT];
                        s_next.inst     = s_reg.d2[3:0];
                        s_next.kernel   = s_reg.d3[31:PSS_KERN_LSB];
                        s_next.scr_base = s_reg.d4[31:PSS_SCR_LSB];
                        s_next.scr_exp  = s_reg.d4[3:0];
                        s_next.sflow    = s_reg.d5[PSS_FLOW_BIT];
                        // Clamped compare: a repeated out-of-range value needs no fence
                        if (new_lim != s_reg.max_thr) begin
                            s_next.fence_due = 1'b1;
                        end
                        if (new_max > PSS_THR_MAX || s_reg.d4[3:0] > PSS_SCR_EXP_MAX
                            || s_reg.d1[PSS_SAMP_LSB +: 3] > PSS_SAMP_MAX) begin
                            s_next.range_err = 1'b1;
                        end
                    end
                end
                PSS_DEV_SKIP: begin
                    s_next.idx = s_reg.idx + 3'h1;
                    if (s_reg.idx == PSS_LAST_IDX) begin
                        s_next.st = PSS_DEV_HDR;
                    end
                end
                default: s_next.st = PSS_DEV_HDR;
            endcase
        end else if (take && link.cmd_kind == PSS_KIND_FENCE) begin
            s_next.fence_due = 1'b0;
        end else if (take && link.cmd_kind == PSS_KIND_DRAW) begin
            if (s_reg.fence_due) begin
                s_next.fence_err = 1'b1;
            end
            if (link.tess_enable != s_reg.enable || link.domain_enable != s_reg.enable) begin
                s_next.tess_err = 1'b1;
            end
        end
        if (patch_done && s_reg.stats) begin
            s_next.invoc = s_reg.invoc + 32'h1;
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            s_reg         <= '0;
            s_reg.st      <= PSS_DEV_HDR;
            s_reg.max_thr <= PSS_THR_RESET;
            s_reg.inst    <= PSS_INST_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign link.cmd_ready         = s_reg.rdy;
    assign KERNEL_ADDR_OUT        = {s_reg.kernel, 6'h00};
    assign SINGLE_FLOW_OUT        = s_reg.sflow;
    assign SAMPLER_CODE_OUT       = s_reg.samp;
    assign SAMPLER_PREFETCH_OUT   = s_reg.samp_pf;
    assign BINDING_PREFETCH_OUT   = s_reg.bt;
    assign FP_ALT_MODE_OUT        = s_reg.fp;
    assign ILLEGAL_EXC_EN_OUT     = s_reg.ill_exc;
    assign SOFTWARE_EXC_EN_OUT    = s_reg.sw_exc;
    assign MAX_THREADS_OUT        = s_reg.max_thr;
    assign STAGE_ENABLE_OUT       = s_reg.enable;
    assign STATS_ENABLE_OUT       = s_reg.stats;
    assign INSTANCE_COUNT_OUT     = s_reg.inst;
    assign SCRATCH_BASE_OUT       = {s_reg.scr_base, 10'h000};
    assign SCRATCH_EXP_OUT        = s_reg.scr_exp;
    assign INVOCATIONS_OUT        = s_reg.invoc;
    assign PACKET_DONE_OUT        = s_reg.pkt_done;
    assign HEADER_ERR_OUT         = s_reg.hdr_err;
    assign RANGE_ERR_OUT          = s_reg.range_err;
    assign FENCE_ERR_OUT          = s_reg.fence_err;
    assign TESS_ERR_OUT           = s_reg.tess_err;
endmodule

// file: pss_pkg.sv
// Shared constants and types for the patch shader stage state path.
// Assumes a single pipeline clock shared by both ends of the link.
package pss_pkg;

    localparam logic [2:0] PSS_CMD_TYPE   = 3'h3;
    localparam logic [1:0] PSS_CMD_SUBT   = 2'h3;
    localparam logic [2:0] PSS_CMD_OPCODE = 3'h0;
    localparam logic [7:0] PSS_CMD_SUBOP  = 8'h1b;
    localparam logic [7:0] PSS_DW_LEN     = 8'h05;
    localparam logic [2:0] PSS_LAST_IDX   = 3'h6;

    localparam int PSS_SAMP_LSB  = 27;
    localparam int PSS_BT_LSB    = 18;
    localparam int PSS_FP_BIT    = 16;
    localparam int PSS_ILL_BIT   = 13;
    localparam int PSS_SWX_BIT   = 7;
    localparam int PSS_EN_BIT    = 31;
    localparam int PSS_STAT_BIT  = 29;
    localparam int PSS_KERN_LSB  = 6;
    localparam int PSS_SCR_LSB   = 10;
    localparam int PSS_FLOW_BIT  = 27;

    localparam logic [2:0] PSS_SAMP_MAX    = 3'h4;
    localparam logic [3:0] PSS_SCR_EXP_MAX = 4'hb;
    localparam logic [6:0] PSS_THR_MAX     = 7'h23;
    localparam logic [6:0] PSS_THR_RESET   = 7'h00;
    localparam logic [3:0] PSS_INST_RESET  = 4'h0;

    typedef enum logic [1:0] {
        PSS_KIND_STATE = 2'b00,
        PSS_KIND_FENCE = 2'b01,
        PSS_KIND_DRAW  = 2'b10
    } pss_kind_t;

    typedef enum logic [1:0] {
        PSS_DEV_HDR  = 2'b00,
        PSS_DEV_BODY = 2'b01,
        PSS_DEV_SKIP = 2'b10
    } pss_dev_st_t;

    typedef enum logic [1:0] {
        PSS_HOST_IDLE  = 2'b00,
        PSS_HOST_SEND  = 2'b01,
        PSS_HOST_FENCE = 2'b10,
        PSS_HOST_DRAW  = 2'b11
    } pss_host_st_t;

    function automatic logic [31:0] pss_header();
        pss_header = {PSS_CMD_TYPE, PSS_CMD_SUBT, PSS_CMD_OPCODE, PSS_CMD_SUBOP,
                      8'h00, PSS_DW_LEN};
    endfunction

    // Sampler prefetch count in samplers; reserved codes prefetch nothing
    function automatic logic [4:0] pss_samp_prefetch(input logic [2:0] code);
        pss_samp_prefetch = (code > PSS_SAMP_MAX) ? 5'h00 : {code, 2'b00};
    endfunction

endpackage

// file: pss_link_if.sv
// Link between the command streamer end and the patch stage decoder end.
// Assumes both ends run on the same clock; no clocking block.
`timescale 1ns/1ps
interface pss_link_if;
    import pss_pkg::*;
    logic        cmd_valid;
    logic        cmd_ready;
    pss_kind_t   cmd_kind;
    logic [31:0] cmd_data;
    logic        tess_enable;
    logic        domain_enable;

    modport host (
        output cmd_valid,
        input  cmd_ready,
        output cmd_kind,
        output cmd_data,
        output tess_enable,
        output domain_enable
    );

    modport dev (
        input  cmd_valid,
        output cmd_ready,
        input  cmd_kind,
        input  cmd_data,
        input  tess_enable,
        input  domain_enable
    );
endinterface

// file: pss_dispatch.sv
// Per-patch instance dispatcher with a simultaneous thread limit.
// Assumes thread_done_in pulses once per finished thread on the same clock.
`timescale 1ns/1ps
module pss_dispatch
    import pss_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       enable_in,
    input  wire logic [6:0] max_thr_in,
    input  wire logic [3:0] inst_cnt_in,
    input  wire logic       patch_valid_in,
    input  wire logic       thread_done_in,
    output logic            patch_ready_out,
    output logic            disp_valid_out,
    output logic [3:0]      disp_inst_out,
    output logic            patch_done_out,
    output logic [7:0]      active_out
);
    typedef struct packed {
        logic       busy;
        logic       ready;
        logic [3:0] cur;
        logic       dvalid;
        logic [3:0] dinst;
        logic       done;
        logic [7:0] active;
    } pss_disp_s_t;

    pss_disp_s_t s_reg;
    pss_disp_s_t s_next;
    logic        room;
    logic        launch;
    logic        retire;

    always_comb begin
        s_next        = s_reg;
        s_next.dvalid = 1'b0;
        s_next.done   = 1'b0;
        s_next.ready  = 1'b1;
        retire        = thread_done_in && (s_reg.active != 8'h00);
        room          = s_reg.active < ({1'b0, max_thr_in} + 8'h01);
        launch        = 1'b0;
        if (!s_reg.busy) begin
            if (patch_valid_in && s_reg.ready && enable_in) begin
                s_next.busy  = 1'b1;
                s_next.ready = 1'b0;
                s_next.cur   = 4'h0;
            end
        end else begin
            s_next.ready = 1'b0;
            if (room) begin
                launch        = 1'b1;
                s_next.dvalid = 1'b1;
                s_next.dinst  = s_reg.cur;
                if (s_reg.cur == inst_cnt_in) begin
                    s_next.busy  = 1'b0;
                    s_next.ready = 1'b1;
                    s_next.done  = 1'b1;
                end else begin
                    s_next.cur = s_reg.cur + 4'h1;
                end
            end
        end
        s_next.active = s_reg.active + {7'h00, launch} - {7'h00, retire};
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign patch_ready_out = s_reg.ready;
    assign disp_valid_out  = s_reg.dvalid;
    assign disp_inst_out   = s_reg.dinst;
    assign patch_done_out  = s_reg.done;
    assign active_out      = s_reg.active;
endmodule

// file: pss_streamer.sv
// Command streamer end: sends the stage state packet, fences and draws.
// Assumes the decoder end shares the clock and answers with cmd_ready.
`timescale 1ns/1ps
module pss_streamer
    import pss_pkg::*;
(
    input  wire logic        CLK_SYS_IN,
    input  wire logic        RST_B_IN,
    pss_link_if.host         link,
    input  wire logic        SEND_IN,
    input  wire logic        DRAW_IN,
    input  wire logic [31:0] STATE_DW1_IN,
    input  wire logic [31:0] STATE_DW2_IN,
    input  wire logic [31:0] STATE_DW3_IN,
    input  wire logic [31:0] STATE_DW4_IN,
    input  wire logic [31:0] STATE_DW5_IN,
    input  wire logic [31:0] STATE_DW6_IN,
    output logic             BUSY_OUT
);
    typedef struct packed {
        pss_host_st_t     st;
        logic [2:0]       idx;
        logic [6:0][31:0] words;
        logic [6:0]       last_max;
        logic             fence_due;
        logic             valid;
        pss_kind_t        kind;
        logic [31:0]      data;
        logic             enable;
        logic             busy;
    } pss_host_s_t;

    pss_host_s_t s_reg;
    pss_host_s_t s_next;
    logic        sent;

    always_comb begin
        s_next = s_reg;
        sent   = s_reg.valid && link.cmd_ready;
        case (s_reg.st)
            PSS_HOST_IDLE: begin
                if (SEND_IN) begin
                    s_next.words = {STATE_DW6_IN, STATE_DW5_IN, STATE_DW4_IN, STATE_DW3_IN,
                                    STATE_DW2_IN, STATE_DW1_IN, pss_header()};
                    if (STATE_DW1_IN[6:0] != s_reg.last_max) begin
                        s_next.fence_due = 1'b1;
                    end
                    s_next.last_max = STATE_DW1_IN[6:0];
                    s_next.st       = PSS_HOST_SEND;
                    s_next.idx      = 3'h0;
                    s_next.valid    = 1'b1;
                    s_next.kind     = PSS_KIND_STATE;
                    s_next.data     = pss_header();
                    s_next.busy     = 1'b1;
                end else if (DRAW_IN) begin
                    s_next.valid = 1'b1;
                    s_next.busy  = 1'b1;
                    s_next.data  = 32'h0;
                    if (s_reg.fence_due) begin
                        s_next.st   = PSS_HOST_FENCE;
                        s_next.kind = PSS_KIND_FENCE;
                    end else begin
                        s_next.st   = PSS_HOST_DRAW;
                        s_next.kind = PSS_KIND_DRAW;
                    end
                end
            end
            PSS_HOST_SEND: begin
                if (sent) begin
                    if (s_reg.idx == PSS_LAST_IDX) begin
                        s_next.enable = s_reg.words[2][PSS_EN_BIT];
                        s_next.valid  = 1'b0;
                        s_next.busy   = 1'b0;
                        s_next.st     = PSS_HOST_IDLE;
                    end else begin
                        s_next.idx  = s_reg.idx + 3'h1;
                        s_next.data = s_reg.words[s_reg.idx + 3'h1];
                    end
                end
            end
            PSS_HOST_FENCE: begin
                if (sent) begin
                    s_next.fence_due = 1'b0;
                    s_next.st        = PSS_HOST_DRAW;
                    s_next.kind      = PSS_KIND_DRAW;
                end
            end
            PSS_HOST_DRAW: begin
                if (sent) begin
                    s_next.valid = 1'b0;
                    s_next.busy  = 1'b0;
                    s_next.st    = PSS_HOST_IDLE;
                end
            end
            default: s_next.st = PSS_HOST_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            s_reg          <= '0;
            s_reg.st       <= PSS_HOST_IDLE;
            s_reg.kind     <= PSS_KIND_STATE;
            s_reg.last_max <= PSS_THR_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign link.cmd_valid     = s_reg.valid;
    assign link.cmd_kind      = s_reg.kind;
    assign link.cmd_data      = s_reg.data;
    assign link.tess_enable   = s_reg.enable;
    assign link.domain_enable = s_reg.enable;
    assign BUSY_OUT           = s_reg.busy;
endmodule

// file: pss_link_checker.sv
// Assertions on the state link and on the decoder's dispatch outputs.
// Assumes one clock and an active-low asynchronous reset on both ends.
`timescale 1ns/1ps
module pss_link_checker
    import pss_pkg::*;
(
    input wire logic        CLK_SYS_IN,
    input wire logic        RST_B_IN,
    input wire logic        cmd_valid,
    input wire pss_kind_t   cmd_kind,
    input wire logic [31:0] cmd_data,
    input wire logic        tess_enable,
    input wire logic        domain_enable,
    input wire logic        PACKET_DONE_OUT,
    input wire logic        DISPATCH_VALID_OUT,
    input wire logic [3:0]  DISPATCH_INSTANCE_OUT,
    input wire logic [3:0]  INSTANCE_COUNT_OUT,
    input wire logic [6:0]  MAX_THREADS_OUT,
    input wire logic        PATCH_VALID_IN,
    input wire logic        PATCH_READY_OUT,
    input wire logic        STAGE_ENABLE_OUT,
    input wire logic [31:0] INVOCATIONS_OUT,
    input wire logic        STATS_ENABLE_OUT
);
    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!RST_B_IN);

    sequence s_start;
        $rose(cmd_valid) && cmd_kind == PSS_KIND_STATE;
    endsequence

    property p_hdr;
        s_start |-> cmd_data == 32'h781b_0005;
    endproperty
    property p_len;
        s_start |-> (cmd_valid && cmd_kind == PSS_KIND_STATE) [*7] ##1 !cmd_valid;
    endproperty
    property p_done;
        s_start |-> ##[7:9] PACKET_DONE_OUT;
    endproperty
    property p_fence;
        cmd_valid && cmd_kind == PSS_KIND_FENCE |=> cmd_valid && cmd_kind == PSS_KIND_DRAW;
    endproperty
    property p_tess;
        tess_enable == domain_enable;
    endproperty
    property p_clamp;
        MAX_THREADS_OUT <= 7'h23;
    endproperty
    property p_inst;
        DISPATCH_VALID_OUT |-> DISPATCH_INSTANCE_OUT <= INSTANCE_COUNT_OUT;
    endproperty
    property p_take;
        PATCH_VALID_IN && PATCH_READY_OUT && STAGE_ENABLE_OUT |=> !PATCH_READY_OUT;
    endproperty
    property p_inv;
        $changed(INVOCATIONS_OUT) |->
            STATS_ENABLE_OUT && INVOCATIONS_OUT == $past(INVOCATIONS_OUT) + 32'h1;
    endproperty

    a_hdr: assert property (p_hdr) else $error("packet header wrong");
    a_len: assert property (p_len) else $error("packet length wrong");
    a_done: assert property (p_done) else $error("packet not committed");
    a_fence: assert property (p_fence) else $error("fence not followed by draw");
    a_tess: assert property (p_tess) else $error("stage enables differ");
    a_clamp: assert property (p_clamp) else $error("thread limit above range");
    a_inst: assert property (p_inst) else $error("instance beyond count");
    a_take: assert property (p_take) else $error("patch ready not dropped");
    a_inv: assert property (p_inv) else $error("invocation count step wrong");

    c_pkt: cover property (PACKET_DONE_OUT);
    c_fence: cover property (cmd_valid && cmd_kind == PSS_KIND_FENCE);
    c_last: cover property (DISPATCH_VALID_OUT && DISPATCH_INSTANCE_OUT == 4'hf);
endmodule

// file: tb_patch_shader_state_decoder.sv
// Testbench joining the streamer and decoder ends over the state link.
// Assumes the 40 MHz clock and one packet, draw or patch at a time.
`timescale 1ns/1ps
module tb_patch_shader_state_decoder;
    import pss_pkg::*;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        send = 1'b0;
    logic        draw = 1'b0;
    logic        pv = 1'b0;
    logic        tdone = 1'b0;
    logic [31:0] dw [1:6];
    logic        busy, prdy, dv, sflow, fpm, ille, swe, sen, sten, pdone;
    logic        herr, rerr, ferr, terr;
    logic [3:0]  dinst, icnt, sexp;
    logic [2:0]  scode;
    logic [4:0]  sampf;
    logic [7:0]  btc, act;
    logic [6:0]  maxt;
    logic [31:0] kaddr, sbase, inv;
    int          fail_count = 0;
    int          checks = 0;

    pss_link_if link ();

    always #12.5 clk = ~clk;

    pss_streamer u_pss_streamer (.CLK_SYS_IN(clk), .RST_B_IN(rst_b), .link(link.host),
        .SEND_IN(send), .DRAW_IN(draw), .STATE_DW1_IN(dw[1]), .STATE_DW2_IN(dw[2]),
        .STATE_DW3_IN(dw[3]), .STATE_DW4_IN(dw[4]), .STATE_DW5_IN(dw[5]),
        .STATE_DW6_IN(dw[6]), .BUSY_OUT(busy));

    pss_decoder u_pss_decoder (.CLK_SYS_IN(clk), .RST_B_IN(rst_b), .link(link.dev),
        .PATCH_VALID_IN(pv), .THREAD_DONE_IN(tdone), .PATCH_READY_OUT(prdy),
        .DISPATCH_VALID_OUT(dv), .DISPATCH_INSTANCE_OUT(dinst), .KERNEL_ADDR_OUT(kaddr),
        .SINGLE_FLOW_OUT(sflow), .SAMPLER_CODE_OUT(scode), .SAMPLER_PREFETCH_OUT(sampf),
        .BINDING_PREFETCH_OUT(btc), .FP_ALT_MODE_OUT(fpm), .ILLEGAL_EXC_EN_OUT(ille),
        .SOFTWARE_EXC_EN_OUT(swe), .MAX_THREADS_OUT(maxt), .STAGE_ENABLE_OUT(sen),
        .STATS_ENABLE_OUT(sten), .INSTANCE_COUNT_OUT(icnt), .SCRATCH_BASE_OUT(sbase),
        .SCRATCH_EXP_OUT(sexp), .ACTIVE_THREADS_OUT(act), .INVOCATIONS_OUT(inv),
        .PACKET_DONE_OUT(pdone), .HEADER_ERR_OUT(herr), .RANGE_ERR_OUT(rerr),
        .FENCE_ERR_OUT(ferr), .TESS_ERR_OUT(terr));

    pss_link_checker u_pss_link_checker (.CLK_SYS_IN(clk), .RST_B_IN(rst_b),
        .cmd_valid(link.cmd_valid), .cmd_kind(link.cmd_kind), .cmd_data(link.cmd_data),
        .tess_enable(link.tess_enable), .domain_enable(link.domain_enable),
        .PACKET_DONE_OUT(pdone), .DISPATCH_VALID_OUT(dv), .DISPATCH_INSTANCE_OUT(dinst),
        .INSTANCE_COUNT_OUT(icnt), .MAX_THREADS_OUT(maxt), .PATCH_VALID_IN(pv),
        .PATCH_READY_OUT(prdy), .STAGE_ENABLE_OUT(sen), .INVOCATIONS_OUT(inv),
        .STATS_ENABLE_OUT(sten));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        if (fail_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Sends one packet; dw6 is all ones since the decoder must ignore it
    task automatic pkt(input logic [2:0] s, input logic [6:0] m, input logic [31:0] d2);
        int n;
        @(posedge clk);
        dw[1] <= {2'h0, s, 1'b0, 8'ha5, 2'b01, 2'h0, 1'b1, 5'h0, 1'b1, m};
        dw[2] <= d2;
        dw[3] <= 32'h1234_5678;
        dw[4] <= 32'habcd_e7fb;
        dw[5] <= 32'h0800_0000;
        dw[6] <= 32'hffff_ffff;
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        for (n = 0; n < 30 && pdone !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk({busy, pdone}, 2'b01);
    endtask

    task automatic t_fields();
        pkt(3'h3, 7'h02, 32'ha000_0002);
        chk(sampf, 5'h0c);
        chk(btc, 8'ha5);
        chk(maxt, 7'h02);
        chk(kaddr, 32'h1234_5640);
        chk({sexp, sbase[31:4]}, 32'hbabc_de40);
        chk(sflow, 1'b1);
        chk({sen, sten, icnt, fpm, ille, swe}, 9'h197);
        chk({link.tess_enable, link.domain_enable}, 2'b11);
        chk({herr, rerr, ferr, terr}, 4'h0);
    endtask

    task automatic t_samp();
        for (int i = 0; i < 8; i++) begin
            pkt(3'(i), 7'h7f, 32'ha000_0002);
            chk(sampf, (i > 4) ? 5'h00 : 5'(i * 4));
            chk({scode, rerr}, {3'(i), 1'b1});
            chk(maxt, 7'h23);
        end
    endtask

    // Limit of one thread, so each done pulse lets the next instance go
    task automatic t_patch(input logic [3:0] ic, input logic st, input logic en);
        logic [31:0] inv0;
        logic        d;
        int          n;
        pkt(3'h0, 7'h00, {en, 1'b0, st, 25'h0, ic});
        inv0 = inv;
        n = 0;
        d = 1'b0;
        @(posedge clk);
        pv <= 1'b1;
        repeat (en ? 1 : 6) @(posedge clk);
        pv <= 1'b0;
        repeat (80) begin
            @(posedge clk);
            tdone <= d;
            #1;
            d = dv;
            if (dv === 1'b1) begin
                chk(dinst, n[3:0]);
                n++;
            end
        end
        chk(32'(n), en ? 32'(ic) + 32'h1 : 32'h0);
        chk(inv, inv0 + 32'(st & en));
        chk({act, link.tess_enable, terr}, {8'h00, en, 1'b0});
    endtask

    task automatic t_draw(input logic fence);
        @(posedge clk);
        draw <= 1'b1;
        @(posedge clk);
        draw <= 1'b0;
        #1;
        chk({link.cmd_valid, link.cmd_kind}, fence ? 3'b101 : 3'b110);
        @(posedge clk);
        #1;
        chk({link.cmd_valid, link.cmd_kind & {2{fence}}}, fence ? 3'b110 : 3'b000);
        @(posedge clk);
        #1;
        chk({link.cmd_valid, busy, ferr, terr}, 4'h0);
    endtask

    initial begin
        for (int i = 1; i <= 6; i++) begin
            dw[i] = 32'h0;
        end
        repeat (2) @(posedge clk);
        #1;
        chk({link.cmd_ready, prdy, dv, pdone, herr, rerr, maxt, inv[7:0]}, 32'h0);
        @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        chk(link.cmd_ready, 1'b1);
        t_fields();
        t_samp();
        t_patch(4'hf, 1'b1, 1'b1);
        t_patch(4'h0, 1'b0, 1'b1);
        t_patch(4'h3, 1'b1, 1'b0);
        pkt(3'h0, 7'h05, 32'ha000_0002);
        t_draw(1'b1);
        t_draw(1'b0);
        complete_run();
    end

    initial begin
        repeat (3000) @(posedge clk);
        fail_count++;
        complete_run();
    end
endmodule
